// File: common/seq_pkg.sv
// Package with constants of the status and error queue block.
package seq_pkg;
  localparam int          DEPTH          = 10;
  localparam int          PTR_W          = 4;
  localparam int          CNT_W          = 4;
  localparam int          CODE_W         = 16;
  localparam int          EN_W           = 16;
  localparam logic [15:0] CODE_NO_ERROR  = 16'h0000;
  localparam logic [15:0] CODE_NO_ARMED  = 16'h00ce;
  localparam logic [15:0] CODE_GET_MSG   = 16'h00cd;
  localparam logic [15:0] CODE_IFC_BOOT  = 16'h00cc;
  localparam logic [15:0] CODE_HW_WDOG   = 16'h00cb;
  localparam logic [15:0] CODE_FW_WDOG   = 16'h00ca;
  localparam logic [15:0] CODE_OVERFLOW  = 16'hfebe;
  localparam logic [15:0] STATUS_ZERO    = 16'h0000;
  localparam logic [15:0] EN_RESET       = 16'h0000;
  localparam int          STB_EAV_BIT    = 2;
  localparam logic [7:0]  STB_EAV_MASK   = 8'h04;
endpackage

// File: hdl/seq_error_queue.sv
// Error/event queue with status register stubs for the remote-control interface adapter.
`timescale 1ns/1ps
module seq_error_queue (
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        ERR_QUERY_I,
  input  wire logic        CLEAR_STATUS_I,
  input  wire logic        TRIGGER_TYPE_COMMAND_I,
  input  wire logic        TRIGGER_ARMED_I,
  input  wire logic        GROUP_TRIGGER_I,
  input  wire logic        MSG_BUSY_I,
  input  wire logic        IFC_BOOT_I,
  input  wire logic        PRIVATE_IFC_ENABLE_I,
  input  wire logic        HW_WDOG_BOOT_I,
  input  wire logic        FW_WDOG_BOOT_I,
  input  wire logic        DEV_ERR_VALID_I,
  input  wire logic [15:0] DEV_ERR_CODE_I,
  input  wire logic        OPER_EN_WRITE_I,
  input  wire logic        QUES_EN_WRITE_I,
  input  wire logic [15:0] EN_WDATA_I,
  output logic             ERR_VALID_O,
  output logic      [15:0] ERR_CODE_O,
  output logic      [15:0] OPER_STATUS_O,
  output logic      [15:0] QUES_STATUS_O,
  output logic      [15:0] OPER_ENABLE_O,
  output logic      [15:0] QUES_ENABLE_O,
  output logic             STB_EAV_O,
  output logic       [3:0] QUEUE_COUNT_O
);

  logic [15:0] mem [seq_pkg::DEPTH];
  logic  [3:0] rd_ptr;
  logic  [3:0] wr_ptr;
  logic  [3:0] count;

  // Event sources in priority order; one entry is pushed per cycle.
  wire logic        ev_fw    = FW_WDOG_BOOT_I;
  wire logic        ev_hw    = HW_WDOG_BOOT_I;
  wire logic        ev_ifc   = IFC_BOOT_I & PRIVATE_IFC_ENABLE_I;
  wire logic        ev_get   = GROUP_TRIGGER_I & MSG_BUSY_I;
  wire logic        ev_arm   = TRIGGER_TYPE_COMMAND_I & ~TRIGGER_ARMED_I;
  wire logic        ev_dev   = DEV_ERR_VALID_I & (DEV_ERR_CODE_I != 16'h0000);
  wire logic        push     = ev_fw | ev_hw | ev_ifc | ev_get | ev_arm | ev_dev;
  wire logic [15:0] push_code = ev_fw  ? seq_pkg::CODE_FW_WDOG :
                                ev_hw  ? seq_pkg::CODE_HW_WDOG :
                                ev_ifc ? seq_pkg::CODE_IFC_BOOT :
                                ev_get ? seq_pkg::CODE_GET_MSG :
                                ev_arm ? seq_pkg::CODE_NO_ARMED : DEV_ERR_CODE_I;
  wire logic        empty    = (count == 4'h0);
  wire logic        full     = (count == 4'(seq_pkg::DEPTH));
  wire logic        pop      = ERR_QUERY_I & ~empty & ~CLEAR_STATUS_I;
  wire logic        do_write = push & ~CLEAR_STATUS_I & (~full | pop);
  wire logic        mark_ovf = push & ~CLEAR_STATUS_I & full & ~pop;
  wire logic  [3:0] last_ptr = (wr_ptr == 4'h0) ? 4'(seq_pkg::DEPTH - 1) : wr_ptr - 4'h1;
  wire logic  [3:0] next_count = CLEAR_STATUS_I ? 4'h0 :
                                 count + {3'h0, do_write} - {3'h0, pop};

  function automatic logic [3:0] inc_ptr(input logic [3:0] p);
    inc_ptr = (p == 4'(seq_pkg::DEPTH - 1)) ? 4'h0 : p + 4'h1;
  endfunction

  always_ff @(posedge REF_CLK_I) begin
    if (do_write) begin
      mem[wr_ptr] <= push_code;
    end else if (mark_ovf) begin
      mem[last_ptr] <= seq_pkg::CODE_OVERFLOW;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_ptr <= 4'h0;
      wr_ptr <= 4'h0;
      count  <= 4'h0;
    end else if (CLEAR_STATUS_I) begin
      rd_ptr <= 4'h0;
      wr_ptr <= 4'h0;
      count  <= 4'h0;
    end else begin
      if (pop) begin
        rd_ptr <= inc_ptr(rd_ptr);
      end
      if (do_write) begin
        wr_ptr <= inc_ptr(wr_ptr);
      end
      count <= next_count;
    end
  end

  // Query answer registered one cycle after the request.
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ERR_VALID_O <= 1'b0;
      ERR_CODE_O  <= 16'h0000;
    end else begin
      ERR_VALID_O <= ERR_QUERY_I;
      if (ERR_QUERY_I) begin
        ERR_CODE_O <= pop ? mem[rd_ptr] : seq_pkg::CODE_NO_ERROR;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      OPER_ENABLE_O <= seq_pkg::EN_RESET;
      QUES_ENABLE_O <= seq_pkg::EN_RESET;
      OPER_STATUS_O <= seq_pkg::STATUS_ZERO;
      QUES_STATUS_O <= seq_pkg::STATUS_ZERO;
      STB_EAV_O     <= 1'b0;
      QUEUE_COUNT_O <= 4'h0;
    end else begin
      if (OPER_EN_WRITE_I) begin
        OPER_ENABLE_O <= EN_WDATA_I;
      end
      if (QUES_EN_WRITE_I) begin
        QUES_ENABLE_O <= EN_WDATA_I;
      end
      OPER_STATUS_O <= seq_pkg::STATUS_ZERO;
      QUES_STATUS_O <= seq_pkg::STATUS_ZERO;
      STB_EAV_O     <= (next_count != 4'h0);
      QUEUE_COUNT_O <= next_count;
    end
  end

  sequence s_query_on_empty;
    ERR_QUERY_I && empty && !CLEAR_STATUS_I;
  endsequence

  sequence s_zero_answer;
    ERR_VALID_O && (ERR_CODE_O == 16'h0000);
  endsequence

  chk_status_zero: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (OPER_STATUS_O == 16'h0000 && QUES_STATUS_O == 16'h0000))
    else $error("Status register not zero.");

  chk_depth_limit: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    count <= 4'd10)
    else $error("Queue count above ten.");

  chk_fifo_order: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    pop |=> (ERR_CODE_O == $past(mem[rd_ptr])))
    else $error("Query did not return the oldest entry.");

  chk_pop_count: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (pop && !do_write) |=> (count == $past(count) - 4'h1))
    else $error("Query did not remove an entry.");

  chk_clear_all: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    CLEAR_STATUS_I |=> (count == 4'h0) && !STB_EAV_O)
    else $error("Clear did not empty the queue.");

  chk_arm_code: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (ev_arm && !ev_fw && !ev_hw && !ev_ifc && !ev_get && do_write) |=>
      (mem[$past(wr_ptr)] == 16'h00ce))
    else $error("Code 206 not queued.");

  chk_get_no_206: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (GROUP_TRIGGER_I && !TRIGGER_TYPE_COMMAND_I && !DEV_ERR_VALID_I && push) |->
      (push_code != seq_pkg::CODE_NO_ARMED))
    else $error("Group trigger queued code 206.");

  chk_full_drop: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    mark_ovf |=> (count == 4'd10) && (wr_ptr == $past(wr_ptr)))
    else $error("Full queue accepted an entry.");

  chk_empty_query: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    s_query_on_empty |=> s_zero_answer)
    else $error("Empty query did not return zero.");

  chk_eav_bit: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    ##1 (STB_EAV_O == (count != 4'h0)))
    else $error("Status byte bit 2 disagrees with queue.");

  chk_answer_valid: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    ERR_QUERY_I |=> ERR_VALID_O)
    else $error("Query not answered.");

  chk_valid_idle: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    !ERR_QUERY_I |=> !ERR_VALID_O)
    else $error("Answer without a query.");

  chk_code_hold: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    !ERR_QUERY_I |=> $stable(ERR_CODE_O))
    else $error("Answer code changed without a query.");

  chk_empty_keep: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (s_query_on_empty and (!push)) |=> (count == 4'h0))
    else $error("Empty query changed the queue.");

  chk_clear_answer: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (ERR_QUERY_I && CLEAR_STATUS_I) |=> (ERR_CODE_O == seq_pkg::CODE_NO_ERROR))
    else $error("Query during clear did not return zero.");

  chk_clear_ptrs: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    CLEAR_STATUS_I |=> (rd_ptr == 4'h0 && wr_ptr == 4'h0))
    else $error("Clear left pointers set.");

  chk_count_out: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (QUEUE_COUNT_O == count))
    else $error("Count output disagrees with queue.");

  chk_push_count: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (do_write && !pop) |=> (count == $past(count) + 4'h1))
    else $error("Push did not add an entry.");

  chk_ovf_mark: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    mark_ovf |=> (mem[$past(last_ptr)] == seq_pkg::CODE_OVERFLOW))
    else $error("Overflow not marked in newest slot.");

  chk_fw_code: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (ev_fw && do_write) |=> (mem[$past(wr_ptr)] == seq_pkg::CODE_FW_WDOG))
    else $error("Code 202 not queued.");

  chk_hw_code: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (ev_hw && !ev_fw && do_write) |=> (mem[$past(wr_ptr)] == seq_pkg::CODE_HW_WDOG))
    else $error("Code 203 not queued.");

  chk_ifc_code: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (ev_ifc && !ev_fw && !ev_hw && do_write) |=>
      (mem[$past(wr_ptr)] == seq_pkg::CODE_IFC_BOOT))
    else $error("Code 204 not queued.");

  chk_ifc_private: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (IFC_BOOT_I && !PRIVATE_IFC_ENABLE_I && !ev_fw && !ev_hw && !ev_get && !ev_arm &&
     !DEV_ERR_VALID_I && !CLEAR_STATUS_I && !ERR_QUERY_I) |=> (count == $past(count)))
    else $error("Code 204 queued without the private option.");

  chk_get_code: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (ev_get && !ev_fw && !ev_hw && !ev_ifc && do_write) |=>
      (mem[$past(wr_ptr)] == seq_pkg::CODE_GET_MSG))
    else $error("Code 205 not queued.");

  chk_armed_quiet: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (TRIGGER_TYPE_COMMAND_I && TRIGGER_ARMED_I && !ev_fw && !ev_hw && !ev_ifc && !ev_get &&
     !DEV_ERR_VALID_I && !CLEAR_STATUS_I && !ERR_QUERY_I) |=> (count == $past(count)))
    else $error("Armed trigger command queued an entry.");

  chk_dev_code: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (ev_dev && !ev_fw && !ev_hw && !ev_ifc && !ev_get && !ev_arm && do_write) |=>
      (mem[$past(wr_ptr)] == $past(DEV_ERR_CODE_I)))
    else $error("Device code not queued as given.");

  chk_zero_dropped: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (DEV_ERR_VALID_I && DEV_ERR_CODE_I == 16'h0000 && !ev_fw && !ev_hw && !ev_ifc &&
     !ev_get && !ev_arm && !CLEAR_STATUS_I && !ERR_QUERY_I) |=> (count == $past(count)))
    else $error("Code zero entered the queue.");

  chk_oper_write: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OPER_EN_WRITE_I |=> (OPER_ENABLE_O == $past(EN_WDATA_I)))
    else $error("Operation enable write lost.");

  chk_ques_write: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    QUES_EN_WRITE_I |=> (QUES_ENABLE_O == $past(EN_WDATA_I)))
    else $error("Questionable enable write lost.");

  chk_oper_hold: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    !OPER_EN_WRITE_I |=> $stable(OPER_ENABLE_O))
    else $error("Operation enable changed without a write.");

  chk_ques_hold: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    !QUES_EN_WRITE_I |=> $stable(QUES_ENABLE_O))
    else $error("Questionable enable changed without a write.");

endmodule

// File: dv/seq_host_model.sv
// Host model that issues error queries and group execute triggers.
`timescale 1ns/1ps
module seq_host_model (
  input  wire logic        clk_i,
  input  wire logic        err_valid_i,
  input  wire logic [15:0] err_code_i,
  output logic             query_o,
  output logic             get_o,
  output logic             busy_o
);
  initial begin
    query_o = 1'b0;
    get_o   = 1'b0;
    busy_o  = 1'b0;
  end
  task automatic query(output logic [15:0] code);
    @(negedge clk_i);
    query_o = 1'b1;
    @(negedge clk_i);
    query_o = 1'b0;
    code    = 16'hxxxx;
    repeat (3) begin
      if (err_valid_i === 1'b1) code = err_code_i;
      @(negedge clk_i);
    end
  endtask
  // A trigger inside a message window is sent only when a scenario asks for it.
  task automatic group_trigger(input logic during_msg);
    @(negedge clk_i);
    busy_o = during_msg;
    get_o  = 1'b1;
    @(negedge clk_i);
    get_o  = 1'b0;
    busy_o = 1'b0;
  endtask
endmodule

// File: dv/tb_seq_error_queue.sv
// Self-checking bench for the error queue against a queue reference model.
`timescale 1ns/1ps
module tb_seq_error_queue;
  logic        clk = 1'b0, rst_n = 1'b0, clr = 1'b0, tcmd = 1'b0, armed = 1'b0;
  logic        ifc = 1'b0, priv = 1'b0, hw = 1'b0, fw = 1'b0, dv = 1'b0;
  logic        oen = 1'b0, qen = 1'b0, qry, get, busy, vld, eav;
  logic [15:0] dc = 16'h0000, wd = 16'h0000, code, ost, qst, oenr, qenr;
  logic [3:0]  cnt;
  int          mismatches = 0, cmp_count = 0;
  int          q[$];
  always #20 clk = ~clk;
  seq_error_queue seq_error_queue_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n),
    .ERR_QUERY_I(qry), .CLEAR_STATUS_I(clr), .TRIGGER_TYPE_COMMAND_I(tcmd),
    .TRIGGER_ARMED_I(armed), .GROUP_TRIGGER_I(get), .MSG_BUSY_I(busy), .IFC_BOOT_I(ifc),
    .PRIVATE_IFC_ENABLE_I(priv), .HW_WDOG_BOOT_I(hw), .FW_WDOG_BOOT_I(fw),
    .DEV_ERR_VALID_I(dv), .DEV_ERR_CODE_I(dc), .OPER_EN_WRITE_I(oen), .QUES_EN_WRITE_I(qen),
    .EN_WDATA_I(wd), .ERR_VALID_O(vld), .ERR_CODE_O(code), .OPER_STATUS_O(ost),
    .QUES_STATUS_O(qst), .OPER_ENABLE_O(oenr), .QUES_ENABLE_O(qenr), .STB_EAV_O(eav),
    .QUEUE_COUNT_O(cnt));
  seq_host_model seq_host_model_inst (.clk_i(clk), .err_valid_i(vld), .err_code_i(code),
    .query_o(qry), .get_o(get), .busy_o(busy));
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  // A full queue keeps its oldest entries and marks the newest slot.
  function automatic void push_ref(input logic [15:0] c);
    if (q.size() < 10) q.push_back(c);
    else q[9] = seq_pkg::CODE_OVERFLOW;
  endfunction
  task automatic pulse(ref logic s, input logic push, input logic [15:0] c);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    if (push) push_ref(c);
    chk("count", {12'h000, cnt}, 16'(q.size()));
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  initial begin
    logic [15:0] r;
    void'($urandom(32'hbe509c8b));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    chk("eav", {15'h0000, eav}, 16'h0000);
    wd = 16'($urandom());
    pulse(oen, 1'b0, 16'h0000);
    wd = ~wd;
    pulse(qen, 1'b0, 16'h0000);
    chk("oen", oenr, ~wd);
    chk("qen", qenr, wd);
    chk("oper", ost, 16'h0000);
    chk("ques", qst, 16'h0000);
    armed = 1'b1;
    pulse(tcmd, 1'b0, 16'h0000);
    armed = 1'b0;
    pulse(tcmd, 1'b1, 16'h00ce);
    seq_host_model_inst.group_trigger(1'b0);
    seq_host_model_inst.group_trigger(1'b1);
    push_ref(16'h00cd);
    chk("count", {12'h000, cnt}, 16'(q.size()));
    pulse(ifc, 1'b0, 16'h0000);
    priv = 1'b1;
    pulse(ifc, 1'b1, 16'h00cc);
    pulse(hw, 1'b1, 16'h00cb);
    pulse(fw, 1'b1, 16'h00ca);
    chk("eav", {15'h0000, eav}, 16'h0001);
    repeat (7) begin
      dc = 16'($urandom()) | 16'h0001;
      pulse(dv, 1'b1, dc);
    end
    repeat (11) begin
      seq_host_model_inst.query(r);
      chk("code", r, q.size() > 0 ? 16'(q.pop_front()) : 16'h0000);
    end
    chk("eav", {15'h0000, eav}, 16'h0000);
    pulse(hw, 1'b1, 16'h00cb);
    pulse(fw, 1'b1, 16'h00ca);
    q.delete();
    pulse(clr, 1'b0, 16'h0000);
    seq_host_model_inst.query(r);
    chk("code", r, 16'h0000);
    print_verdict();
  end
endmodule
